/* testbench/testbench.sv */
// Watchdog testbench: reset options, refresh, stop modes, ratios, underflow
`timescale 1ns/100ps

module testbench;
  // ==========================================
  // Signals
  logic        MCLK, RESET_N, AUTO, RWR, SWR, PRS, LSS, ACT, STP, WTM;
  logic [7:0]  OPT, RDAT;
  logic        RST_REQ, IRQ, IGN, RUN;
  logic [13:0] CNT, v;
  int          failures, check_count, cyc, ign_n, t0, t1, d;
  logic [13:0] exp_cnt [4] = '{wdt_pkg::CNT_SEL0, wdt_pkg::CNT_SEL1, wdt_pkg::CNT_SEL2, wdt_pkg::CNT_SEL3};

  wdt_top uut (.MCLK(MCLK), .RESET_N(RESET_N), .OPT_BYTE_TWO(OPT), .AUTO_START_OPT(AUTO),
    .REFRESH_WR(RWR), .REFRESH_DATA(RDAT), .START_WR(SWR), .PRESCALER_RATIO_SELECT(PRS),
    .LOW_SPEED_CLOCK_SELECT(LSS), .UNDERFLOW_ACTION_SELECT(ACT), .STOP_MODE(STP), .WAIT_MODE(WTM),
    .WDT_RESET_REQ(RST_REQ), .WDT_IRQ(IRQ), .REFRESH_IGNORED(IGN), .COUNTING(RUN), .COUNT_VALUE(CNT));

  // ==========================================
  // Clock, cycle count and refused-refresh tally
  initial
  begin
    MCLK = 1'b0;
    forever #2.5 MCLK = ~MCLK;
  end
  always @(posedge MCLK)
  begin
    cyc <= cyc + 1;
    if (IGN === 1'b1) ign_n <= ign_n + 1;
  end

  // ==========================================
  // Shared tasks
  task chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1)
    begin
      failures++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask : chk

  // Options are only latched while reset is low, so set them first
  task do_reset(input logic [7:0] o, input logic a);
    @(negedge MCLK) RESET_N = 1'b0;
    OPT = o;
    AUTO = a;
    repeat (10) @(negedge MCLK);
    RESET_N = 1'b1;
    repeat (2) @(negedge MCLK);
  endtask : do_reset

  // A leading idle edge keeps one write's strobe apart from the next
  task wr_ref(input logic [7:0] b);
    @(negedge MCLK);
    RWR  = 1'b1;
    RDAT = b;
    @(negedge MCLK);
    RWR  = 1'b0;
  endtask : wr_ref

  // Pulses stand one cycle; a falling-edge poll sees each one
  task wait_pulse(input logic s, input int lim, output int t);
    int i;
    for (i = 0; i < lim; i++)
    begin
      @(negedge MCLK);
      if ((s ? RST_REQ : IRQ) === 1'b1) break;
    end
    t = cyc;
    chk(i < lim, "underflow pulse missing");
  endtask : wait_pulse

  task report_and_stop;
    $display("Checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  // ==========================================
  // Watchdog against a hang
  initial
  begin
    #200000;
    failures++;
    report_and_stop();
  end

  // ==========================================
  // Main sequence
  initial
  begin
    {RESET_N, AUTO, RWR, SWR, PRS, ACT, STP, WTM, RDAT} = '0;
    {failures, check_count, cyc, ign_n} = '0;
    LSS = 1'b1;
    OPT = 8'hFF;
    for (int c = 0; c < 4; c++)
    begin
      do_reset(8'hF0 | c[7:0], 1'b1);
      chk(CNT === exp_cnt[c], "reload per period code");
      chk(RUN === 1'b0, "counting before start write");
    end
    do_reset(wdt_pkg::OPT2_ERASED, 1'b1);
    chk(CNT === wdt_pkg::CNT_SEL3, "erased byte count");
    do_reset(8'hFC, 1'b1);
    d = ign_n;
    wr_ref(wdt_pkg::REFRESH_FIRST);
    wr_ref(wdt_pkg::REFRESH_SECOND);
    @(negedge MCLK);
    chk(ign_n - d == 1 && CNT === 14'h03FF, "refresh while stopped");
    SWR = 1'b1;
    @(negedge MCLK) SWR = 1'b0;
    chk(RUN === 1'b1, "start write");
    repeat (20) @(negedge MCLK);
    d = 14'h03FF - CNT;
    chk(d >= 9 && d <= 11, "down count at ratio 2");
    // Both power modes freeze, then resume from the held count
    for (int m = 0; m < 2; m++)
    begin
      {STP, WTM} = m ? 2'b01 : 2'b10;
      repeat (2) @(negedge MCLK);
      v = CNT;
      repeat (20) @(negedge MCLK);
      chk(CNT === v, "count held in low-power mode");
      {STP, WTM} = 2'b00;
      repeat (10) @(negedge MCLK);
      chk(CNT < v && CNT > v - 14'h0008, "resume from held count");
    end
    wr_ref(wdt_pkg::REFRESH_FIRST);
    wr_ref(wdt_pkg::REFRESH_SECOND);
    @(negedge MCLK);
    chk(CNT >= 14'h03FC, "refresh pair reload");
    // A lone second byte must not reload
    repeat (20) @(negedge MCLK);
    wr_ref(wdt_pkg::REFRESH_SECOND);
    repeat (2) @(negedge MCLK);
    chk(CNT < 14'h03F4, "lone FFh write reloaded");
    LSS = 1'b0;
    for (int r = 0; r < 2; r++)
    begin
      PRS = r[0];
      repeat (300) @(negedge MCLK);
      v = CNT;
      repeat (256) @(negedge MCLK);
      d = int'(v - CNT) - (r ? 2 : 16);
      chk(d >= -1 && d <= 1, "prescaler ratio 16 or 128");
    end
    LSS = 1'b1;
    wait_pulse(1'b0, 3000, t0);
    @(negedge MCLK);
    chk(CNT >= 14'h03FD && RST_REQ === 1'b0, "reload after underflow");
    wait_pulse(1'b0, 3000, t1);
    chk(t1 - t0 == 2048, "interrupt period");
    ACT = 1'b1;
    wait_pulse(1'b1, 3000, t0);
    chk(t0 - t1 == 2048, "reset request period");
    do_reset(8'hF0, 1'b0);
    chk(RUN === 1'b1, "auto-start at release");
    d = ign_n;
    wr_ref(wdt_pkg::REFRESH_FIRST);
    wr_ref(wdt_pkg::REFRESH_SECOND);
    @(negedge MCLK);
    chk(ign_n - d == 1 && CNT < wdt_pkg::CNT_SEL0, "refresh outside 25% window");
    ACT = 1'b0;
    wait_pulse(1'b0, 3000, t0);
    for (int i = 0; i < 2000 && CNT >= 14'h00F0; i++) @(negedge MCLK);
    d = ign_n;
    wr_ref(wdt_pkg::REFRESH_FIRST);
    wr_ref(wdt_pkg::REFRESH_SECOND);
    @(negedge MCLK);
    chk(ign_n == d && CNT >= 14'h03FC, "refresh inside 25% window");
    // Middle window codes: refused near the top, taken once inside
    for (int w = 1; w < 3; w++)
    begin
      do_reset(8'hF0 | 8'(w << 2), 1'b0);
      d = ign_n;
      wr_ref(wdt_pkg::REFRESH_FIRST);
      wr_ref(wdt_pkg::REFRESH_SECOND);
      @(negedge MCLK);
      chk(ign_n - d == 1 && CNT < wdt_pkg::CNT_SEL0, "refresh before 50/75% window");
      for (int i = 0; i < 2000 && CNT >= 14'(256 * (w + 1) - 16); i++) @(negedge MCLK);
      d = ign_n;
      wr_ref(wdt_pkg::REFRESH_FIRST);
      wr_ref(wdt_pkg::REFRESH_SECOND);
      @(negedge MCLK);
      chk(ign_n == d && CNT >= 14'h03FC, "refresh inside 50/75% window");
    end
    report_and_stop();
  end
endmodule : testbench

/* verilog/wdt_pkg.sv */
// Watchdog constants: option byte layout, count values, ratios, states
package wdt_pkg;

  // ==========================================
  // Option byte two layout
  localparam int          UFS_LSB     = 0;
  localparam int          RCS_LSB     = 2;
  localparam logic [7:0]  OPT2_ERASED = 8'hFF;

  // ==========================================
  // Count values selected by the period field
  localparam logic [13:0] CNT_SEL0 = 14'h03FF;
  localparam logic [13:0] CNT_SEL1 = 14'h0FFF;
  localparam logic [13:0] CNT_SEL2 = 14'h1FFF;
  localparam logic [13:0] CNT_SEL3 = 14'h3FFF;

  // ==========================================
  // Prescaler division ratios
  localparam logic [7:0]  DIV_FAST = 8'h10;
  localparam logic [7:0]  DIV_SLOW = 8'h80;
  localparam logic [7:0]  DIV_LOCO = 8'h02;

  // ==========================================
  // Refresh register write sequence
  localparam logic [7:0]  REFRESH_FIRST  = 8'h00;
  localparam logic [7:0]  REFRESH_SECOND = 8'hFF;

  // ==========================================
  // Counter run state
  typedef enum logic {
    ST_STOPPED,
    ST_RUNNING
  } wdt_state_t;

endpackage : wdt_pkg

/* verilog/wdt_top.sv */
// Watchdog timer core with flash option configuration
`timescale 1ns/100ps

module wdt_top #(
  parameter int PRESC_W = 7
) (
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        RESET_N,
  // Option data read from flash
  input  wire logic [7:0]  OPT_BYTE_TWO,
  input  wire logic        AUTO_START_OPT,
  // Software register writes
  input  wire logic        REFRESH_WR,
  input  wire logic [7:0]  REFRESH_DATA,
  input  wire logic        START_WR,
  // Clock and action controls
  input  wire logic        PRESCALER_RATIO_SELECT,
  input  wire logic        LOW_SPEED_CLOCK_SELECT,
  input  wire logic        UNDERFLOW_ACTION_SELECT,
  // Power modes
  input  wire logic        STOP_MODE,
  input  wire logic        WAIT_MODE,
  // Status and events
  output logic             WDT_RESET_REQ,
  output logic             WDT_IRQ,
  output logic             REFRESH_IGNORED,
  output logic             COUNTING,
  output logic [13:0]      COUNT_VALUE
);

  // ==========================================
  // Parameter check
  // Elaboration stops here if the prescaler cannot reach a ratio of 128
  if (PRESC_W < 7)
  begin : g_presc_check
    $error("PRESC_W too small for a ratio of 128");
  end

  // ==========================================
  // State
  wdt_pkg::wdt_state_t state_reg, state_next;
  logic [7:0]          opt2_reg, opt2_next;
  logic [PRESC_W-1:0]  presc_reg, presc_next;
  logic [13:0]         cnt_reg, cnt_next;
  logic                armed_reg, armed_next;
  logic                rst_req_reg, rst_req_next;
  logic                irq_reg, irq_next;
  logic                ign_reg, ign_next;

  // ==========================================
  // Decoded settings
  logic [13:0]         reload_val;
  logic [7:0]          ratio;
  logic [14:0]         quarter;
  logic [14:0]         win_lim;
  logic                run_en;
  logic                tick;
  logic                in_window;
  logic                refresh_hit;
  logic [7:0]          opt_src;

  // While reset is held the incoming byte is decoded directly, so the
  // very first period already runs on the selected count
  assign opt_src = RESET_N ? opt2_reg : OPT_BYTE_TWO;

  // Count value from the period field
  always_comb
  begin
    case (opt_src[wdt_pkg::UFS_LSB +: 2])
      2'b00:   reload_val = wdt_pkg::CNT_SEL0;
      2'b01:   reload_val = wdt_pkg::CNT_SEL1;
      2'b10:   reload_val = wdt_pkg::CNT_SEL2;
      default: reload_val = wdt_pkg::CNT_SEL3;
    endcase
  end

  // Ratio: low-speed clock overrides the select bit
  always_comb
  begin
    if (LOW_SPEED_CLOCK_SELECT)
      ratio = wdt_pkg::DIV_LOCO;
    else if (PRESCALER_RATIO_SELECT)
      ratio = wdt_pkg::DIV_SLOW;
    else
      ratio = wdt_pkg::DIV_FAST;
  end

  // Window: last N quarters of the full interval (count+1 ticks)
  // Every count is one below a multiple of four, so quarters are exact
  assign quarter   = ({1'b0, reload_val} + 15'h0001) >> 2;
  assign win_lim   = 15'(quarter * (15'(opt2_reg[wdt_pkg::RCS_LSB +: 2]) + 15'h0001));
  assign in_window = {1'b0, cnt_reg} < win_lim;

  // Halted in stop or wait; count held
  assign run_en = (state_reg == wdt_pkg::ST_RUNNING) && !STOP_MODE && !WAIT_MODE;
  assign tick   = run_en && (presc_reg == PRESC_W'(ratio - 8'h01));

  // Second write of the refresh pair
  assign refresh_hit = REFRESH_WR && armed_reg && (REFRESH_DATA == wdt_pkg::REFRESH_SECOND);

  // ==========================================
  // Next-state logic
  always_comb
  begin
    state_next   = state_reg;
    opt2_next    = opt2_reg;
    presc_next   = presc_reg;
    cnt_next     = cnt_reg;
    armed_next   = armed_reg;
    rst_req_next = 1'b0;
    irq_next     = 1'b0;
    ign_next     = 1'b0;
    if (!RESET_N)
    begin
      // Option data is sampled while reset is held
      opt2_next  = OPT_BYTE_TWO;
      presc_next = '0;
      // Selected count from the start, auto-start included
      cnt_next   = reload_val;
      armed_next = 1'b0;
      if (AUTO_START_OPT)
        state_next = wdt_pkg::ST_STOPPED;
      else
        state_next = wdt_pkg::ST_RUNNING;
    end
    else
    begin
      // Counter reload after reset uses the latched option byte
      if (state_reg == wdt_pkg::ST_STOPPED)
      begin
        cnt_next = reload_val;
        if (START_WR)
          state_next = wdt_pkg::ST_RUNNING;
      end
      // Prescaler wraps at the selected ratio, never cleared by refresh
      if (run_en)
      begin
        if (tick)
          presc_next = '0;
        else
          presc_next = presc_reg + PRESC_W'(1);
      end
      // Down count and underflow
      if (tick)
      begin
        if (cnt_reg == 14'h0000)
        begin
          cnt_next = reload_val;
          if (UNDERFLOW_ACTION_SELECT)
            rst_req_next = 1'b1;
          else
            irq_next = 1'b1;
        end
        else
          cnt_next = cnt_reg - 14'h0001;
      end
      // Refresh pair tracking; any other write breaks the pair
      if (REFRESH_WR)
        armed_next = (REFRESH_DATA == wdt_pkg::REFRESH_FIRST);
      // Refresh outside the window or while stopped is dropped
      if (refresh_hit)
      begin
        if (state_reg == wdt_pkg::ST_RUNNING && in_window)
          cnt_next = reload_val;
        else
          ign_next = 1'b1;
      end
    end
  end

  // ==========================================
  // Registers
  always_ff @(posedge MCLK)
  begin
    state_reg   <= state_next;
    opt2_reg    <= opt2_next;
    presc_reg   <= presc_next;
    cnt_reg     <= cnt_next;
    armed_reg   <= armed_next;
    rst_req_reg <= rst_req_next;
    irq_reg     <= irq_next;
    ign_reg     <= ign_next;
  end

  // ==========================================
  // Outputs
  assign WDT_RESET_REQ   = rst_req_reg;
  assign WDT_IRQ         = irq_reg;
  assign REFRESH_IGNORED = ign_reg;
  assign COUNTING        = (state_reg == wdt_pkg::ST_RUNNING);
  assign COUNT_VALUE     = cnt_reg;

  // ==========================================
  // Assertions
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);

  AST_UNDERFLOW_RESET: assert property (
    tick && cnt_reg == 14'h0000 && UNDERFLOW_ACTION_SELECT |=> WDT_RESET_REQ && !WDT_IRQ)
    else $error("underflow did not request reset");

  AST_UNDERFLOW_IRQ: assert property (
    tick && cnt_reg == 14'h0000 && !UNDERFLOW_ACTION_SELECT |=> WDT_IRQ && !WDT_RESET_REQ)
    else $error("underflow did not raise interrupt");

  AST_RELOAD_VALUE: assert property (
    tick && cnt_reg == 14'h0000 |=> COUNT_VALUE == $past(reload_val))
    else $error("underflow reload wrong");

  AST_HALT_HOLDS: assert property (
    (STOP_MODE || WAIT_MODE) && !refresh_hit |=> $stable(COUNT_VALUE) && $stable(presc_reg))
    else $error("count moved in stop or wait");

  AST_DECREMENT: assert property (
    tick && cnt_reg != 14'h0000 && !refresh_hit |=> COUNT_VALUE == $past(cnt_reg) - 14'h0001)
    else $error("count did not decrement");

  AST_FAST_RATIO: assert property (
    run_en && !LOW_SPEED_CLOCK_SELECT && !PRESCALER_RATIO_SELECT &&
    presc_reg == PRESC_W'(wdt_pkg::DIV_FAST - 8'h01) |=> presc_reg == '0)
    else $error("ratio 16 not honoured");

  AST_LOCO_RATIO: assert property (
    run_en && LOW_SPEED_CLOCK_SELECT &&
    presc_reg == PRESC_W'(wdt_pkg::DIV_LOCO - 8'h01) |=> presc_reg == '0)
    else $error("ratio 2 not honoured");

  AST_SLOW_RATIO: assert property (
    run_en && !LOW_SPEED_CLOCK_SELECT && PRESCALER_RATIO_SELECT &&
    presc_reg == PRESC_W'(wdt_pkg::DIV_SLOW - 8'h01) |=> presc_reg == '0)
    else $error("ratio 128 not honoured");

  AST_REFRESH_RELOAD: assert property (
    refresh_hit && COUNTING && in_window |=> COUNT_VALUE == $past(reload_val) && !REFRESH_IGNORED)
    else $error("refresh did not reload");

  AST_REFRESH_KEEPS_PRESC: assert property (
    refresh_hit && run_en && !tick |=> presc_reg == $past(presc_reg) + PRESC_W'(1))
    else $error("refresh touched prescaler");

  AST_START_WRITE: assert property (
    !COUNTING && START_WR |=> COUNTING)
    else $error("start write ignored");

  AST_WINDOW_FULL: assert property (
    opt2_reg[wdt_pkg::RCS_LSB +: 2] == 2'b11 |-> in_window)
    else $error("100 percent window refused");

  AST_AUTO_START: assert property (
    @(posedge MCLK) disable iff (1'b0) !RESET_N && !AUTO_START_OPT ##1 RESET_N |-> COUNTING)
    else $error("auto start failed");

  // Checks that must look at reset itself carry their own disable,
  // since the default one would switch them off exactly there
  AST_PRESC_RESET: assert property (
    @(posedge MCLK) disable iff (1'b0) !RESET_N |=> presc_reg == '0)
    else $error("prescaler not cleared by reset");

  AST_RESET_LOAD: assert property (
    $rose(RESET_N) |-> COUNT_VALUE == reload_val)
    else $error("first count not the selected value");

  AST_REFRESH_REFUSED: assert property (
    refresh_hit && COUNTING && !in_window |=> REFRESH_IGNORED && COUNT_VALUE <= $past(cnt_reg))
    else $error("refresh outside window accepted");

  AST_STOPPED_REFRESH: assert property (
    refresh_hit && !COUNTING |=> REFRESH_IGNORED)
    else $error("refresh while stopped not refused");

  AST_STOPPED_HOLDS: assert property (
    !COUNTING && !START_WR |=> !COUNTING && !WDT_IRQ && !WDT_RESET_REQ)
    else $error("stopped counter started or fired");

  // Requests are single-cycle pulses; a stuck one would be taken twice
  AST_IRQ_ONE_CYCLE: assert property (
    WDT_IRQ |=> !WDT_IRQ)
    else $error("interrupt request longer than one cycle");

  AST_RESET_ONE_CYCLE: assert property (
    WDT_RESET_REQ |=> !WDT_RESET_REQ)
    else $error("reset request longer than one cycle");

  // Main scenarios
  COV_UNDERFLOW_RESET: cover property (WDT_RESET_REQ);
  COV_UNDERFLOW_IRQ:   cover property (WDT_IRQ);
  COV_REFRESH_OK:      cover property (refresh_hit && COUNTING && in_window);
  COV_REFRESH_DROP:    cover property (REFRESH_IGNORED);
  COV_START_WRITE:     cover property (!COUNTING && START_WR);

endmodule : wdt_top
